// file: rtl/scb_pkg.sv
/*
 * Constants and carrier types for the sensor control register bank.
 * Assumes a serial-bus decoder on the same clock that delivers single-byte accesses.
 */
package scb_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_GAIN = 8'h00;
    localparam logic [7:0] ADDR_COMMON_CTRL_ONE = 8'h03;
    localparam logic [7:0] ADDR_ORIENT = 8'h04;
    localparam logic [7:0] ADDR_PRECHARGE = 8'h08;
    localparam logic [7:0] ADDR_COMMON_CTRL_TWO = 8'h09;
    localparam logic [7:0] ADDR_PID_HIGH = 8'h0a;
    localparam logic [7:0] ADDR_PID_LOW = 8'h0b;
    localparam logic [7:0] ADDR_COMMON_CTRL_THREE = 8'h0c;
    localparam logic [7:0] ADDR_COMMON_CTRL_FOUR = 8'h0d;
    localparam logic [7:0] ADDR_EXPOSURE = 8'h10;
    localparam logic [7:0] ADDR_CLOCK_RATE_CTRL = 8'h11;
    localparam logic [7:0] ADDR_BANK = 8'hff;

    // Writable storage: address, writable-bit mask and reset value per entry
    localparam int NUM_REGS = 9;
    localparam logic [7:0] REG_ADDR [NUM_REGS] = '{ADDR_GAIN, ADDR_COMMON_CTRL_ONE, ADDR_ORIENT, ADDR_PRECHARGE,
        ADDR_COMMON_CTRL_TWO, ADDR_COMMON_CTRL_THREE, ADDR_COMMON_CTRL_FOUR, ADDR_EXPOSURE, ADDR_CLOCK_RATE_CTRL};
    localparam logic [7:0] REG_MASK [NUM_REGS] = '{8'hff, 8'hcf, 8'hdb, 8'hff, 8'h17, 8'h07, 8'h04, 8'hff, 8'hbf};
    localparam logic [7:0] REG_RESET [NUM_REGS] = '{8'h00, 8'h0f, 8'h20, 8'h40, 8'h00, 8'h38, 8'h07, 8'h33, 8'h00};
    localparam int IDX_GAIN = 0;
    localparam int IDX_COMMON_CTRL_ONE = 1;
    localparam int IDX_ORIENT = 2;
    localparam int IDX_COMMON_CTRL_TWO = 4;
    localparam int IDX_COMMON_CTRL_THREE = 5;
    localparam int IDX_COMMON_CTRL_FOUR = 6;
    localparam int IDX_EXPOSURE = 7;
    localparam int IDX_CLOCK_RATE_CTRL = 8;

    // Bank select: bit 0 writable, reserved bits read back their reset pattern
    localparam logic BANK_RESET = 1'b1;
    localparam logic [7:0] BANK_RSVD_READ = 8'h7e;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Field positions
    localparam int GAIN_NIBBLE_W = 4;
    localparam int COMMON_CTRL_ONE_DUMMY_HI = 7;
    localparam int COMMON_CTRL_ONE_VERTICAL_END_UPPER_LO = 2;
    localparam int COMMON_CTRL_ONE_VERTICAL_START_UPPER_LO = 0;
    localparam int ORIENT_MIRROR = 7;
    localparam int ORIENT_FLIP = 6;
    localparam int ORIENT_VREF0 = 4;
    localparam int ORIENT_HREF0 = 3;
    localparam int COMMON_CTRL_TWO_STANDBY = 4;
    localparam int COMMON_CTRL_TWO_PIN_REUSE = 2;
    localparam int COMMON_CTRL_THREE_BAND_50 = 2;
    localparam int COMMON_CTRL_THREE_BAND_AUTO = 1;
    localparam int COMMON_CTRL_THREE_SNAPSHOT = 0;
    localparam int COMMON_CTRL_FOUR_HOLD = 2;
    localparam int CLOCK_RATE_CTRL_DOUBLER = 7;
    localparam int CLOCK_RATE_CTRL_DIV_W = 6;

    // Dummy-frame codes and drive-strength codes
    localparam logic [2:0] DUMMY_FOR_01 = 3'h1;
    localparam logic [2:0] DUMMY_FOR_10 = 3'h3;
    localparam logic [2:0] DUMMY_FOR_11 = 3'h7;
    localparam logic [2:0] DRIVE_FOR_00 = 3'h1;
    localparam logic [2:0] DRIVE_FOR_01 = 3'h3;
    localparam logic [2:0] DRIVE_FOR_10 = 3'h2;
    localparam logic [2:0] DRIVE_FOR_11 = 3'h4;

    // Single-byte register access from the serial-bus decoder
    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } scb_req_t;

    // Vertical window, both ends 10 bits
    typedef struct packed {
        logic [9:0] v_end;
        logic [9:0] v_start;
    } scb_window_t;
endpackage : scb_pkg

// file: rtl/scb_bank.sv
/*
 * Sensor control register bank: storage, read-back and decoded controls.
 * Assumes a same-clock serial-bus decoder issuing one access per valid pulse,
 * and pin inputs that are asynchronous to i_clock.
 */
`timescale 1ns/10ps
// What this block does
// (R1) Gain equals bit-factor product times nibble term
// (R2) Host clears auto-gain bit for manual gain
// (R3) Auto-gain bit: zero manual, one automatic
// (R4) Dummy-frame code allows 1, 3, 7
// (R5) Common one supplies vertical window low bits
// (R6) Orientation: mirror, flip, reference, exposure bits
// (R7) Exposure assembled from three registers
// (R8) Exposure time limited to frame period
// (R9) Common two bit four selects standby
// (R10) Pin reuse turns pins into sync selects
// (R11) Drive select codes give 1,3,2,4x
// (R12) Product code read only, writes ignored
// (R13) Manual banding: zero 60 Hz, one 50 Hz
// (R14) Auto banding overrides manual choice
// (R15) Snapshot: live video or single frame
// (R16) Power-down: tri-state or hold data pins
// (R17) Internal clock is input over divider+1
// (R18) Clock register bit seven enables doublers
// (R19) Bank reached only while bank bit set
// (R20) Reserved places ignore writes, read stable
module scb_bank #(
    parameter logic [7:0] PRODUCT_CODE_HIGH = 8'h5a, // Arbitrary value
    parameter logic [7:0] PRODUCT_CODE_LOW = 8'ha5 // Arbitrary value
) (
    input wire logic i_clock, // System clock, 100 MHz
    input wire logic i_resetn, // Asynchronous reset, active low
    input wire logic i_clock_enable, // Freezes all state while low
    input wire logic i_req_valid, // Register access strobe
    input wire scb_pkg::scb_req_t i_req, // Register access request
    output logic [7:0] o_rdata, // Read data
    output logic o_rvalid, // Read data valid pulse
    input wire logic i_agc_auto, // Auto-gain select bit from common control eight
    input wire logic [5:0] i_exposure_high, // Exposure bits 15:10 from the high exposure register
    input wire logic [7:0] i_vertical_end_upper, // Vertical end upper 8 bits
    input wire logic [7:0] i_vertical_start_upper, // Vertical start upper 8 bits
    input wire logic [15:0] i_line_period, // Line period in cycles
    input wire logic [31:0] i_frame_period, // Frame period in cycles
    input wire logic i_detected_50hz, // Banding detector result
    input wire logic i_power_down_pin, // Power-down pin, asynchronous
    input wire logic i_reset_pin_low, // Reset pin, asynchronous, active low
    input wire logic [7:0] i_pixel_data, // Pixel data to the output pins
    output logic [8:0] o_gain_x16, // Manual gain in sixteenths
    output logic o_gain_manual, // Manual gain governs
    output logic [2:0] o_dummy_frames, // Allowed dummy frames, zero if reserved
    output scb_pkg::scb_window_t o_window, // Vertical window lines
    output logic o_mirror, // Horizontal mirror
    output logic o_flip, // Vertical flip
    output logic o_vref_bit0, // Vertical reference bit 0
    output logic o_href_bit0, // Horizontal reference bit 0
    output logic [15:0] o_exposure_value, // Assembled exposure value
    output logic [31:0] o_exposure_time, // Exposure in cycles, frame-limited
    output logic o_standby, // Standby mode
    output logic o_power_down, // Power-down function of the pin
    output logic o_reset_request, // Reset function of the pin
    output logic o_vertical_sync_select, // Vertical sync select from reused pin
    output logic o_horizontal_sync_select, // Horizontal sync select from reused pin
    output logic [2:0] o_drive_strength, // Output drive multiple
    output logic o_band_50hz, // Effective banding, one for 50 Hz
    output logic o_band_auto, // Banding decided automatically
    output logic o_single_frame, // Snapshot gives single frame
    output logic [7:0] o_data, // Data output pins
    output logic o_data_oe, // Data pin output enable
    output logic o_internal_clk_en, // Divided internal clock pulse
    output logic o_doubler_on // Frequency doublers on
);
    import scb_pkg::*;

    logic [7:0] regs [NUM_REGS];
    logic bank_sensor;
    logic [1:0] pd_sync;
    logic [1:0] rst_sync;
    logic [5:0] div_count;
    logic [7:0] next_rdata;
    logic [4:0] gain_factor;
    logic [8:0] next_gain_x16;
    logic [31:0] raw_exposure;
    logic [1:0] dummy_code;
    logic [1:0] drive_code;

    // Register storage, one entry per writable register; reserved bits keep reset value
    generate
        for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
            always_ff @(posedge i_clock or negedge i_resetn) begin
                if (!i_resetn) begin
                    regs[g] <= REG_RESET[g];
                end else if (i_clock_enable && i_req_valid && i_req.write && bank_sensor
                             && i_req.addr == REG_ADDR[g]) begin // [R19]
                    regs[g] <= (regs[g] & ~REG_MASK[g]) | (i_req.wdata & REG_MASK[g]); // [R20]
                end
            end
        end
    endgenerate

    // Bank select, reachable in either bank
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            bank_sensor <= BANK_RESET;
        end else if (i_clock_enable && i_req_valid && i_req.write && i_req.addr == ADDR_BANK) begin
            bank_sensor <= i_req.wdata[0]; // [R19]
        end
    end

    // Read decode; product code is constant and unmapped addresses read zero
    always_comb begin
        next_rdata = UNMAPPED_READ; // [R20]
        if (i_req.addr == ADDR_BANK) begin
            next_rdata = BANK_RSVD_READ | {7'h00, bank_sensor};
        end else if (bank_sensor) begin // [R19]
            if (i_req.addr == ADDR_PID_HIGH) begin
                next_rdata = PRODUCT_CODE_HIGH; // [R12]
            end else if (i_req.addr == ADDR_PID_LOW) begin
                next_rdata = PRODUCT_CODE_LOW; // [R12]
            end
            for (int k = 0; k < NUM_REGS; k++) begin
                if (i_req.addr == REG_ADDR[k]) begin
                    next_rdata = regs[k];
                end
            end
        end
    end

    // Registered read answer
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
            o_rvalid <= 1'b0;
        end else if (i_clock_enable) begin
            o_rvalid <= i_req_valid && !i_req.write;
            if (i_req_valid && !i_req.write) begin
                o_rdata <= next_rdata;
            end
        end
    end

    // Gain: product of bit factors (1..16) times (16 + nibble), in sixteenths
    always_comb begin
        gain_factor = 5'h01;
        for (int b = GAIN_NIBBLE_W; b < 8; b++) begin
            gain_factor = regs[IDX_GAIN][b] ? 5'(gain_factor << 1) : gain_factor;
        end
        next_gain_x16 = 9'(gain_factor * (9'h010 + {5'h00, regs[IDX_GAIN][3:0]})); // [R1]
    end

    assign raw_exposure = i_line_period * o_exposure_value; // [R8]
    assign dummy_code = regs[IDX_COMMON_CTRL_ONE][COMMON_CTRL_ONE_DUMMY_HI -: 2];
    assign drive_code = regs[IDX_COMMON_CTRL_TWO][1:0];

    // Decoded controls from flip-flops
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_gain_x16 <= 9'h010;
            o_gain_manual <= 1'b0;
            o_dummy_frames <= 3'h0;
            o_window <= '0;
            o_mirror <= 1'b0;
            o_flip <= 1'b0;
            o_vref_bit0 <= 1'b0;
            o_href_bit0 <= 1'b0;
            o_exposure_value <= 16'h0000;
            o_exposure_time <= 32'h0000_0000;
            o_standby <= 1'b0;
            o_drive_strength <= DRIVE_FOR_00;
            o_band_50hz <= 1'b0;
            o_band_auto <= 1'b0;
            o_single_frame <= 1'b0;
            o_doubler_on <= 1'b0;
        end else if (i_clock_enable) begin
            o_gain_x16 <= next_gain_x16; // [R1]
            o_gain_manual <= !i_agc_auto; // [R3]
            unique case (dummy_code)
                2'b01: o_dummy_frames <= DUMMY_FOR_01; // [R4]
                2'b10: o_dummy_frames <= DUMMY_FOR_10;
                2'b11: o_dummy_frames <= DUMMY_FOR_11;
                2'b00: o_dummy_frames <= 3'h0;
            endcase
            o_window.v_end <= {i_vertical_end_upper, regs[IDX_COMMON_CTRL_ONE][COMMON_CTRL_ONE_VERTICAL_END_UPPER_LO +: 2]}; // [R5]
            o_window.v_start <= {i_vertical_start_upper, regs[IDX_COMMON_CTRL_ONE][COMMON_CTRL_ONE_VERTICAL_START_UPPER_LO +: 2]}; // [R5]
            o_mirror <= regs[IDX_ORIENT][ORIENT_MIRROR]; // [R6]
            o_flip <= regs[IDX_ORIENT][ORIENT_FLIP]; // [R6]
            o_vref_bit0 <= regs[IDX_ORIENT][ORIENT_VREF0]; // [R6]
            o_href_bit0 <= regs[IDX_ORIENT][ORIENT_HREF0]; // [R6]
            o_exposure_value <= {i_exposure_high, regs[IDX_EXPOSURE], regs[IDX_ORIENT][1:0]}; // [R7]
            o_exposure_time <= (raw_exposure > i_frame_period) ? i_frame_period : raw_exposure; // [R8]
            o_standby <= regs[IDX_COMMON_CTRL_TWO][COMMON_CTRL_TWO_STANDBY]; // [R9]
            unique case (drive_code)
                2'b00: o_drive_strength <= DRIVE_FOR_00; // [R11]
                2'b01: o_drive_strength <= DRIVE_FOR_01;
                2'b10: o_drive_strength <= DRIVE_FOR_10;
                2'b11: o_drive_strength <= DRIVE_FOR_11;
            endcase
            o_band_auto <= regs[IDX_COMMON_CTRL_THREE][COMMON_CTRL_THREE_BAND_AUTO]; // [R14]
            o_band_50hz <= regs[IDX_COMMON_CTRL_THREE][COMMON_CTRL_THREE_BAND_AUTO] ? i_detected_50hz
                                                          : regs[IDX_COMMON_CTRL_THREE][COMMON_CTRL_THREE_BAND_50]; // [R13] [R14]
            o_single_frame <= regs[IDX_COMMON_CTRL_THREE][COMMON_CTRL_THREE_SNAPSHOT]; // [R15]
            o_doubler_on <= regs[IDX_CLOCK_RATE_CTRL][CLOCK_RATE_CTRL_DOUBLER]; // [R18]
        end
    end

    // Two-flop synchronisers for the pins
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            pd_sync <= 2'b00;
            rst_sync <= 2'b11;
        end else if (i_clock_enable) begin
            pd_sync <= {pd_sync[0], i_power_down_pin};
            rst_sync <= {rst_sync[0], i_reset_pin_low};
        end
    end

    // Pin functions: normal or reused as sync selects
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_power_down <= 1'b0;
            o_reset_request <= 1'b0;
            o_vertical_sync_select <= 1'b0;
            o_horizontal_sync_select <= 1'b0;
        end else if (i_clock_enable) begin
            if (regs[IDX_COMMON_CTRL_TWO][COMMON_CTRL_TWO_PIN_REUSE]) begin // [R10]
                o_power_down <= 1'b0;
                o_reset_request <= 1'b0;
                o_vertical_sync_select <= pd_sync[1];
                o_horizontal_sync_select <= rst_sync[1];
            end else begin
                o_power_down <= pd_sync[1];
                o_reset_request <= !rst_sync[1];
                o_vertical_sync_select <= 1'b0;
                o_horizontal_sync_select <= 1'b0;
            end
        end
    end

    // Data pins: drive live data, or tri-state / hold while powered down
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_data <= 8'h00;
            o_data_oe <= 1'b0;
        end else if (i_clock_enable) begin
            if (!o_power_down) begin
                o_data <= i_pixel_data;
                o_data_oe <= 1'b1;
            end else if (!regs[IDX_COMMON_CTRL_FOUR][COMMON_CTRL_FOUR_HOLD]) begin
                o_data_oe <= 1'b0; // [R16]
            end
        end
    end

    // Internal clock divider: one pulse every divider+1 cycles, stopped in standby
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            div_count <= 6'h00;
            o_internal_clk_en <= 1'b0;
        end else if (i_clock_enable) begin
            if (o_standby) begin
                div_count <= 6'h00;
                o_internal_clk_en <= 1'b0;
            end else if (div_count >= regs[IDX_CLOCK_RATE_CTRL][CLOCK_RATE_CTRL_DIV_W-1:0]) begin
                div_count <= 6'h00;
                o_internal_clk_en <= 1'b1; // [R17]
            end else begin
                div_count <= div_count + 6'h01;
                o_internal_clk_en <= 1'b0;
            end
        end
    end
endmodule : scb_bank

// file: bench/scb_bank_monitor.sv
/* Port checker for the sensor control register bank.
   Bound to scb_bank; its driver drops the clock enable low for one ignored write. */
`timescale 1ns/10ps
module scb_bank_monitor #(
    parameter logic [7:0] PRODUCT_CODE_HIGH = 8'h5a, // Arbitrary value
    parameter logic [7:0] PRODUCT_CODE_LOW = 8'ha5 // Arbitrary value
) (
    input wire logic i_clock, // Clock
    input wire logic i_resetn, // Reset, active low
    input wire logic i_clock_enable, // Run enable
    input wire logic i_req_valid, // Access strobe
    input wire scb_pkg::scb_req_t i_req, // Access
    input wire logic [7:0] o_rdata, // Read data
    input wire logic o_rvalid, // Read answer
    input wire logic i_agc_auto, // Auto gain
    input wire logic [5:0] i_exposure_high, // Exposure top
    input wire logic [15:0] i_line_period, // Line period
    input wire logic [31:0] i_frame_period, // Frame period
    input wire logic i_detected_50hz, // Detector
    input wire logic [8:0] o_gain_x16, // Gain
    input wire logic o_gain_manual, // Manual gain
    input wire logic [15:0] o_exposure_value, // Exposure
    input wire logic [31:0] o_exposure_time, // Exposure time
    input wire logic o_standby, // Standby
    input wire logic [2:0] o_drive_strength, // Drive
    input wire logic o_band_50hz, // Banding
    input wire logic o_band_auto // Auto banding
);
    import scb_pkg::*;
    localparam logic [2:0] DRV [4] = '{3'h1, 3'h3, 3'h2, 3'h4};
    logic [7:0] sh [32]; // Shadow of the low registers
    logic bnk; // Shadow of the bank bit
    logic up; // Low on the first edge after reset
    logic wr;
    logic [31:0] lim; // Frame-limited exposure product
    assign wr = i_clock_enable && i_req_valid && i_req.write;
    assign lim = (i_line_period * o_exposure_value > i_frame_period) ? i_frame_period
        : i_line_period * o_exposure_value;
    // Gain in sixteenths from the gain byte
    function automatic logic [8:0] gx(input logic [7:0] g);
        return (9'h10 + 9'(g[3:0])) << ({2'h0, g[7]} + g[6] + g[5] + g[4]);
    endfunction : gx
    // Track register contents from host writes
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            for (int i = 0; i < NUM_REGS; i++)
                sh[REG_ADDR[i][4:0]] <= REG_RESET[i];
            bnk <= BANK_RESET;
            up <= 1'b0;
        end else begin
            up <= i_clock_enable;
            if (wr && i_req.addr == ADDR_BANK)
                bnk <= i_req.wdata[0];
            if (wr && bnk && i_req.addr < 8'h20)
                sh[i_req.addr[4:0]] <= i_req.wdata;
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);
    sequence rd_s;
        i_clock_enable && i_req_valid && !i_req.write;
    endsequence
    read_answer_a: assert property (rd_s |=> o_rvalid)
        else $error("read gave no answer");
    product_code_a: assert property (rd_s ##0 bnk && i_req.addr[7:1] == 7'h05
        |=> o_rdata == ($past(i_req.addr[0]) ? PRODUCT_CODE_LOW : PRODUCT_CODE_HIGH)) else $error("bad product code");
    other_bank_a: assert property (rd_s ##0 !bnk && i_req.addr != ADDR_BANK |=> o_rdata == 8'h00)
        else $error("other bank read not zero");
    gain_calc_a: assert property (up |-> o_gain_x16 == gx($past(sh[0])))
        else $error("gain value wrong");
    auto_gain_a: assert property (up |-> o_gain_manual != $past(i_agc_auto))
        else $error("gain mode wrong");
    drive_code_a: assert property (up |-> o_drive_strength == DRV[$past(sh[9][1:0])])
        else $error("drive strength wrong");
    standby_mode_a: assert property (up |-> o_standby == $past(sh[9][4]))
        else $error("standby wrong");
    band_select_a: assert property (up |-> o_band_auto == $past(sh[12][1]) && o_band_50hz ==
        ($past(sh[12][1]) ? $past(i_detected_50hz) : $past(sh[12][2]))) else $error("banding wrong");
    exposure_join_a: assert property (up |-> o_exposure_value ==
        {$past(i_exposure_high), $past(sh[16]), $past(sh[4][1:0])}) else $error("exposure value wrong");
    exposure_limit_a: assert property (up |-> o_exposure_time == $past(lim))
        else $error("exposure time wrong");
endmodule : scb_bank_monitor

// file: bench/scb_host.sv
/* Host controller model issuing single-byte register accesses.
   Assumes the bench calls its tasks on the bank clock. */
`timescale 1ns/10ps
module scb_host (
    input wire logic i_clock, // Bank clock
    output logic o_req_valid, // Access strobe
    output scb_pkg::scb_req_t o_req, // Access
    output logic o_agc_auto // Auto-gain select level
);
    import scb_pkg::*;
    // Quiet bus at time zero
    initial begin
        o_req_valid = 1'b0;
        o_req = '0;
        o_agc_auto = 1'b1;
    end
    // One access per cycle, held until the next edge samples it
    task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        #1;
        o_req_valid = 1'b1;
        o_req = '{w, a, d};
    endtask : acc
    // Release the strobe; address and data turn over
    task idle();
        @(posedge i_clock);
        #1;
        o_req_valid = 1'b0;
        o_req = ~o_req;
    endtask : idle
    // Clear the auto bit when m is high so the written gain governs
    task manual(input logic m);
        o_agc_auto = !m;
    endtask : manual
endmodule : scb_host

// file: bench/tb.sv
/* Bench top: clock, reset, scenarios, read checker and verdict.
   Assumes the host model drives the access bus and the checker is bound here. */
`timescale 1ns/10ps
module tb;
    import scb_pkg::*;
    localparam logic [7:0] PH = 8'h3c; // Arbitrary value
    localparam logic [7:0] PL = 8'hc3; // Arbitrary value
    localparam logic [2:0] DUMMY_EXP [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    localparam logic [2:0] DRIVE_EXP [4] = '{3'h1, 3'h3, 3'h2, 3'h4};
    logic i_clock, i_resetn, i_clock_enable, i_req_valid, i_agc_auto, i_detected_50hz, i_power_down_pin;
    logic i_reset_pin_low, o_rvalid, o_gain_manual, o_mirror, o_flip, o_vref_bit0, o_href_bit0, o_standby;
    logic o_power_down, o_reset_request, o_vertical_sync_select, o_horizontal_sync_select, o_band_50hz;
    logic o_band_auto, o_single_frame, o_data_oe, o_internal_clk_en, o_doubler_on;
    logic [5:0] i_exposure_high;
    logic [7:0] i_vertical_end_upper, i_vertical_start_upper, i_pixel_data, o_rdata, o_data, v;
    logic [15:0] i_line_period, o_exposure_value;
    logic [31:0] i_frame_period, o_exposure_time;
    logic [8:0] o_gain_x16;
    logic [2:0] o_dummy_frames, o_drive_strength;
    scb_req_t i_req;
    scb_window_t o_window;
    logic [7:0] expq [$];
    int fails, total_checks, seed, n;
    scb_bank #(.PRODUCT_CODE_HIGH(PH), .PRODUCT_CODE_LOW(PL)) u_dut (.*);
    scb_host u_host (.i_clock(i_clock), .o_req_valid(i_req_valid), .o_req(i_req), .o_agc_auto(i_agc_auto));
    // 100 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    // Compare and count
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    // Bus helpers; reads note their expected answer
    task wr(input logic [7:0] a, input logic [7:0] d);
        u_host.acc(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        u_host.acc(1'b0, a, 8'h00);
        expq.push_back(e);
    endtask : rd
    task wait_n(input int k);
        repeat (k) @(posedge i_clock);
        #1;
    endtask : wait_n
    task settle();
        u_host.idle();
        wait_n(2);
    endtask : settle
    task rnd();
        {i_exposure_high, i_vertical_end_upper, i_vertical_start_upper} = 22'($random(seed));
        {i_line_period, i_detected_50hz} = 17'($random(seed));
        i_frame_period = $random(seed);
        i_pixel_data = 8'($random(seed));
    endtask : rnd
    // Match each read answer against the oldest note
    always @(negedge i_clock) begin
        if (o_rvalid === 1'b1) begin
            if (expq.size() > 0)
                chk(o_rdata, expq.pop_front());
            else
                chk(o_rdata, 32'hffff_ffff);
        end
    end
    // Scenarios
    initial begin
        seed = 16;
        i_resetn = 1'b0;
        i_clock_enable = 1'b1;
        i_power_down_pin = 1'b0;
        i_reset_pin_low = 1'b1;
        rnd();
        repeat (12) @(posedge i_clock);
        #1 i_resetn = 1'b1;
        for (int i = 0; i < NUM_REGS; i++)
            rd(REG_ADDR[i], REG_RESET[i]);
        rd(ADDR_PID_HIGH, PH);
        rd(8'h01, 8'h00);
        rd(ADDR_BANK, 8'h7f);
        for (int i = 0; i < NUM_REGS; i++) begin
            v = 8'($random(seed));
            wr(REG_ADDR[i], v);
            rd(REG_ADDR[i], (v & REG_MASK[i]) | (REG_RESET[i] & ~REG_MASK[i]));
        end
        wr(ADDR_PID_LOW, ~PL);
        rd(ADDR_PID_LOW, PL);
        wr(ADDR_GAIN, 8'h9f);
        wr(ADDR_BANK, 8'h00);
        wr(ADDR_GAIN, 8'h5a);
        rd(ADDR_GAIN, 8'h00);
        rd(ADDR_BANK, 8'h7e);
        wr(ADDR_BANK, 8'h01);
        rd(ADDR_GAIN, 8'h9f);
        for (int i = 0; i < 4; i++) begin
            rnd();
            u_host.manual(i[0]);
            wr(ADDR_COMMON_CTRL_ONE, {i[1:0], 2'h0, i[1:0], ~i[1:0]});
            wr(ADDR_COMMON_CTRL_TWO, {6'h0, i[1:0]});
            wr(ADDR_ORIENT, {i[1:0], 1'b1, i[1:0], 3'h0});
            wr(ADDR_COMMON_CTRL_THREE, {5'h0, i[0], 1'b0, i[1]});
            wr(ADDR_CLOCK_RATE_CTRL, {i[0], 7'h0});
            settle();
            chk(o_dummy_frames, DUMMY_EXP[i]);
            chk(o_window, {i_vertical_end_upper, i[1:0], i_vertical_start_upper, ~i[1:0]});
            chk({o_mirror, o_flip, o_vref_bit0, o_href_bit0}, {i[1:0], i[1:0]});
            chk(o_drive_strength, DRIVE_EXP[i]);
            chk({o_single_frame, o_band_50hz, o_doubler_on, o_gain_manual}, {i[1], i[0], i[0], i[0]});
        end
        // Detector says 50 Hz while the manual bit says 60 Hz
        i_detected_50hz = 1'b1;
        wr(ADDR_GAIN, 8'hff);
        wr(ADDR_COMMON_CTRL_THREE, 8'h02);
        settle();
        chk(o_gain_x16, 9'h1f0);
        chk(o_band_50hz, i_detected_50hz);
        // Frozen bank ignores a write; the gain byte still reads all ones
        i_clock_enable = 1'b0;
        wr(ADDR_GAIN, 8'h00);
        u_host.idle();
        i_clock_enable = 1'b1;
        rd(ADDR_GAIN, 8'hff);
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_COMMON_CTRL_TWO, (k == 2) ? 8'h10 : 8'h00);
            wr(ADDR_CLOCK_RATE_CTRL, (k == 1) ? 8'h83 : 8'h00);
            settle();
            n = 0;
            repeat (40) begin
                wait_n(1);
                n += o_internal_clk_en;
            end
            chk(n, (k == 0) ? 40 : (k == 1) ? 10 : 0);
        end
        wr(ADDR_COMMON_CTRL_TWO, 8'h00);
        wr(ADDR_COMMON_CTRL_FOUR, 8'h00);
        settle();
        chk({o_data_oe, o_data}, {1'b1, i_pixel_data});
        i_power_down_pin = 1'b1;
        wait_n(4);
        chk({o_power_down, o_data_oe}, 2'h2);
        wr(ADDR_COMMON_CTRL_FOUR, 8'h04);
        u_host.idle();
        i_power_down_pin = 1'b0;
        wait_n(4);
        v = i_pixel_data;
        i_power_down_pin = 1'b1;
        wait_n(4);
        i_pixel_data = ~v;
        wait_n(2);
        chk({o_data_oe, o_data}, {1'b1, v});
        // Normal pin functions first, then the same pins reused as sync selects
        i_reset_pin_low = 1'b0;
        wait_n(4);
        chk({o_power_down, o_reset_request}, 2'h3);
        wr(ADDR_COMMON_CTRL_TWO, 8'h04);
        u_host.idle();
        wait_n(2);
        chk({o_power_down, o_reset_request, o_vertical_sync_select, o_horizontal_sync_select}, 4'h2);
        chk(expq.size(), 0);
        finish_test();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        fails++;
        finish_test();
    end
endmodule : tb
bind scb_bank scb_bank_monitor #(.PRODUCT_CODE_HIGH(PRODUCT_CODE_HIGH), .PRODUCT_CODE_LOW(PRODUCT_CODE_LOW)) u_mon (.*);
